/* File: core/hts_pkg.sv */
// Operation
// (R01) answer only address 0x40, bit eight selects direction
// (R02) acknowledge own address on ninth clock
// (R03) first written byte becomes register pointer
// (R04) next written byte stored at pointer, acknowledged; the port stores it only when the pointer is the control register
// (R05) controller writes 0x01/0x11 to control register
// (R06) controller reads via pointer write, repeated start
// (R07) read returns register selected by pointer
// (R08) controller nacks single byte then stops
// (R09) acked result high byte followed by low byte
// (R10) controller nacks second result byte, stops
// (R11) status bit 0 is completion flag
// (R12) registers 1, 2 hold latest result
// (R13) control bits: fast 5, temp 4, heater 1, start 0
// (R14) identity register: code high nibble, low zero
// (R15) controller writes only the five registers
// (R16) reserved bits written zero, read undefined
// (R17) controller may hold chip select for standby
// (R18) flag reads 1 busy, 0 when done
// (R19) chip select active low, high powers down
// (R20) supports bus rates up to 400 kHz
// (R21) fast mode shortens conversion 35 ms to 18 ms
// (R22) start sets busy until result stored
package hts_pkg;

  // ---------------------------------------------------------------
  // bus and register map
  // ---------------------------------------------------------------
  localparam logic [6:0] HTS_BUS_ADDR     = 7'h40;
  localparam logic [7:0] HTS_REG_STATUS   = 8'h00;
  localparam logic [7:0] HTS_REG_RES_HI   = 8'h01;
  localparam logic [7:0] HTS_REG_RES_LO   = 8'h02;
  localparam logic [7:0] HTS_REG_CONTROL  = 8'h03;
  localparam logic [7:0] HTS_REG_IDENTITY = 8'h11;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int         HTS_BIT_FAST    = 5;
  localparam int         HTS_BIT_TEMP    = 4;
  localparam int         HTS_BIT_HEATER  = 1;
  localparam int         HTS_BIT_START   = 0;
  localparam int         HTS_BIT_BUSY    = 0;
  localparam logic [7:0] HTS_CTRL_MASK   = 8'h33;
  localparam logic [7:0] HTS_CTRL_RESET  = 8'h00;
  localparam logic [7:0] HTS_RESULT_RESET = 8'h00;
  localparam logic       HTS_BUSY_RESET  = 1'b1;
  // identity code: arbitrary value
  localparam logic [3:0] HTS_IDENTITY_CODE = 4'ha;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int HTS_CLK_HZ       = 50_000_000;
  localparam int HTS_CONV_MS      = 35;
  localparam int HTS_CONV_FAST_MS = 18;
  localparam int HTS_CONV_CYCLES      = HTS_CONV_MS * (HTS_CLK_HZ / 1000);
  localparam int HTS_CONV_FAST_CYCLES = HTS_CONV_FAST_MS * (HTS_CLK_HZ / 1000);

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    HTS_IDLE, HTS_ADDR, HTS_ADDR_ACK, HTS_WR_BYTE, HTS_WR_ACK,
    HTS_RD_BYTE, HTS_RD_ACK
  } hts_bus_state_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } hts_pins_t;

  typedef struct packed {
    logic       strobe;
    logic [7:0] index;
    logic [7:0] data;
  } hts_wr_t;
endpackage

/* File: core/hts_result_mem.sv */
`timescale 1ns/1ps
// two-entry result store with registered read
module hts_result_mem
  import hts_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_wr_en,
  input  wire logic [15:0] i_wr_data,
  input  wire logic        i_rd_sel,
  output logic       [7:0] o_rd_data
);
  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
    logic [7:0] rd;
  } hts_mem_state_t;

  hts_mem_state_t state_reg;
  hts_mem_state_t state_next;

  // ---------------------------------------------------------------
  // store and read
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    if (i_wr_en) begin
      state_next.hi = i_wr_data[15:8]; // R12
      state_next.lo = i_wr_data[7:0];
    end
    state_next.rd = i_rd_sel ? state_reg.lo : state_reg.hi;
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg <= '{HTS_RESULT_RESET, HTS_RESULT_RESET, HTS_RESULT_RESET};
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_rd_data = state_reg.rd;
endmodule // hts_result_mem

/* File: core/hts_sensor_port.sv */
`timescale 1ns/1ps
// i2c target register port of the humidity and temperature sensor
module hts_sensor_port
  import hts_pkg::*;
#(
  parameter int CONV_CYCLES      = HTS_CONV_CYCLES,
  parameter int CONV_FAST_CYCLES = HTS_CONV_FAST_CYCLES
)
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  input  wire logic        i_chip_sel_n,
  input  wire logic [15:0] i_meas_result,
  output logic             o_sda_out,
  output logic             o_sda_oe,
  output logic             o_heater_on,
  output logic             o_temp_sel,
  output logic             o_fast_mode,
  output logic             o_powered,
  output logic             o_conv_active
);
  typedef struct packed {
    hts_pins_t      s1;
    hts_pins_t      s2;
    hts_pins_t      prev;
    logic           cs1;
    logic           cs2;
    hts_bus_state_t st;
    logic [2:0]     bit_cnt;
    logic [7:0]     shift;
    logic           rd_dir;
    logic           have_ptr;
    logic [7:0]     ptr;
    logic [7:0]     ctrl;
    logic           busy;
    logic [31:0]    conv_cnt;
    logic           sda_oe;
    logic           powered;
  } hts_port_state_t;

  hts_port_state_t state_reg;
  hts_port_state_t state_next;
  logic [7:0]      res_byte;
  logic            res_wr;
  logic            res_sel;

  // register contents for a read at the given pointer
  function automatic logic [7:0] read_mux(input logic [7:0] p, input logic [7:0] ctrl,
                                          input logic busy, input logic [7:0] res);
    unique case (p)
      HTS_REG_STATUS:   read_mux = {7'h00, busy}; // R11 R18 R16
      HTS_REG_RES_HI,
      HTS_REG_RES_LO:   read_mux = res; // R12
      HTS_REG_CONTROL:  read_mux = ctrl & HTS_CTRL_MASK;
      HTS_REG_IDENTITY: read_mux = {HTS_IDENTITY_CODE, 4'h0}; // R14
      default:          read_mux = 8'h00;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // result store
  // ---------------------------------------------------------------
  hts_result_mem u_mem (
    .i_sys_clk (i_sys_clk),
    .i_reset_n (i_reset_n),
    .i_wr_en   (res_wr),
    .i_wr_data (i_meas_result),
    .i_rd_sel  (res_sel),
    .o_rd_data (res_byte)
  );

  // ---------------------------------------------------------------
  // bus engine and conversion timer
  // ---------------------------------------------------------------
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic [7:0] byte_in;

  always_comb begin
    state_next    = state_reg;
    res_wr        = 1'b0;
    res_sel       = (state_reg.ptr == HTS_REG_RES_LO);
    scl_rise      = state_reg.s2.scl & ~state_reg.prev.scl;
    scl_fall      = ~state_reg.s2.scl & state_reg.prev.scl;
    start_cond    = state_reg.s2.scl & state_reg.prev.scl
                    & state_reg.prev.sda & ~state_reg.s2.sda;
    stop_cond     = state_reg.s2.scl & state_reg.prev.scl
                    & ~state_reg.prev.sda & state_reg.s2.sda;
    byte_in       = {state_reg.shift[6:0], state_reg.s2.sda};
    // pin synchronisers, samples up to 400 kHz comfortably
    state_next.s1   = '{i_scl, i_sda};
    state_next.s2   = state_reg.s1;
    state_next.prev = state_reg.s2; // R20
    state_next.cs1  = i_chip_sel_n;
    state_next.cs2  = state_reg.cs1;
    state_next.powered = ~state_reg.cs2; // R19

    // conversion timer
    if (state_reg.busy) begin
      if (state_reg.conv_cnt == 32'h0) begin
        state_next.busy = 1'b0; // R18
        res_wr          = 1'b1; // R22
      end else begin
        state_next.conv_cnt = state_reg.conv_cnt - 32'h1;
      end
    end

    if (!state_reg.powered) begin
      state_next.st     = HTS_IDLE; // R19
      state_next.sda_oe = 1'b0;
    end else if (start_cond) begin
      state_next.st      = HTS_ADDR;
      state_next.bit_cnt = 3'h0;
      state_next.sda_oe  = 1'b0;
    end else if (stop_cond) begin
      state_next.st     = HTS_IDLE;
      state_next.sda_oe = 1'b0;
    end else begin
      unique case (state_reg.st)
        HTS_IDLE: state_next.sda_oe = 1'b0;
        HTS_ADDR: if (scl_rise) begin
          state_next.shift   = byte_in;
          state_next.bit_cnt = state_reg.bit_cnt + 3'h1;
          if (state_reg.bit_cnt == 3'h7) begin
            if (state_reg.shift[6:0] == HTS_BUS_ADDR) begin // R01
              state_next.rd_dir = state_reg.s2.sda;
              state_next.st     = HTS_ADDR_ACK;
            end else begin
              state_next.st = HTS_IDLE;
            end
          end
        end
        HTS_ADDR_ACK, HTS_WR_ACK: begin
          if (scl_fall && !state_reg.sda_oe) begin
            state_next.sda_oe = 1'b1; // R02
          end else if (scl_fall && state_reg.sda_oe) begin
            state_next.bit_cnt = 3'h0;
            if (state_reg.st == HTS_ADDR_ACK && state_reg.rd_dir) begin
              state_next.st     = HTS_RD_BYTE; // R07
              state_next.shift  = read_mux(state_reg.ptr, state_reg.ctrl,
                                           state_reg.busy, res_byte);
              state_next.sda_oe = ~read_mux(state_reg.ptr, state_reg.ctrl,
                                            state_reg.busy, res_byte) >> 7 != 8'h0;
            end else begin
              state_next.st     = HTS_WR_BYTE;
              state_next.sda_oe = 1'b0;
            end
          end
        end
        HTS_WR_BYTE: if (scl_rise) begin
          state_next.shift   = byte_in;
          state_next.bit_cnt = state_reg.bit_cnt + 3'h1;
          if (state_reg.bit_cnt == 3'h7) begin
            state_next.st = HTS_WR_ACK;
            if (!state_reg.have_ptr) begin
              state_next.ptr      = byte_in; // R03
              state_next.have_ptr = 1'b1;
            end else if (state_reg.ptr == HTS_REG_CONTROL) begin
              state_next.ctrl = byte_in & HTS_CTRL_MASK; // R04 R13
              if (byte_in[HTS_BIT_START]) begin
                state_next.busy     = 1'b1; // R22
                state_next.conv_cnt = byte_in[HTS_BIT_FAST] // R21
                                      ? 32'(CONV_FAST_CYCLES) : 32'(CONV_CYCLES);
              end
            end
          end
        end
        HTS_RD_BYTE: if (scl_fall) begin
          state_next.bit_cnt = state_reg.bit_cnt + 3'h1;
          state_next.shift   = {state_reg.shift[6:0], 1'b0};
          if (state_reg.bit_cnt == 3'h7) begin
            state_next.st     = HTS_RD_ACK;
            state_next.sda_oe = 1'b0;
          end else begin
            state_next.sda_oe = ~state_reg.shift[6];
          end
        end
        HTS_RD_ACK: if (scl_rise) begin
          if (state_reg.s2.sda) begin
            state_next.st = HTS_IDLE; // nack ends the read
          end else if (state_reg.ptr == HTS_REG_RES_HI) begin
            state_next.ptr = HTS_REG_RES_LO; // R09
            state_next.st  = HTS_WR_ACK;
            state_next.rd_dir = 1'b1;
          end else begin
            state_next.st = HTS_IDLE;
          end
        end
        default: state_next.st = HTS_IDLE;
      endcase
    end
    // a new write address frame starts a fresh pointer byte
    if (start_cond) state_next.have_ptr = 1'b0;
    if (state_reg.st == HTS_WR_ACK && state_reg.rd_dir && scl_fall) begin
      // second result byte after acked first one
      state_next.st      = HTS_RD_BYTE;
      state_next.bit_cnt = 3'h0;
      state_next.shift   = res_byte;
      state_next.sda_oe  = ~res_byte[7];
    end
    state_next.ctrl[HTS_BIT_START] = state_next.busy & state_next.ctrl[HTS_BIT_START];
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg          <= '0;
      state_reg.s1       <= '{1'b1, 1'b1};
      state_reg.s2       <= '{1'b1, 1'b1};
      state_reg.prev     <= '{1'b1, 1'b1};
      state_reg.cs1      <= 1'b1;
      state_reg.cs2      <= 1'b1;
      state_reg.st       <= HTS_IDLE;
      state_reg.ctrl     <= HTS_CTRL_RESET;
      state_reg.busy     <= HTS_BUSY_RESET;
      state_reg.conv_cnt <= 32'h0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign o_sda_out     = 1'b0;
  assign o_sda_oe      = state_reg.sda_oe;
  assign o_heater_on   = state_reg.ctrl[HTS_BIT_HEATER];
  assign o_temp_sel    = state_reg.ctrl[HTS_BIT_TEMP];
  assign o_fast_mode   = state_reg.ctrl[HTS_BIT_FAST];
  assign o_powered     = state_reg.powered;
  assign o_conv_active = state_reg.busy;
endmodule // hts_sensor_port

/* File: verification/hts_sensor_port_asserts.sv */
`timescale 1ns/1ps
// ----------------------------------------
// port checker
// ----------------------------------------
module hts_sensor_port_asserts
  import hts_pkg::*;
#(
  parameter int CONV_CYCLES      = 200,
  parameter int CONV_FAST_CYCLES = 100
)
(
  input wire logic        i_sys_clk,
  input wire logic        i_reset_n,
  input wire logic        i_scl,
  input wire logic        i_sda,
  input wire logic        i_chip_sel_n,
  input wire logic [15:0] i_meas_result,
  input wire logic        o_sda_out,
  input wire logic        o_sda_oe,
  input wire logic        o_heater_on,
  input wire logic        o_temp_sel,
  input wire logic        o_fast_mode,
  input wire logic        o_powered,
  input wire logic        o_conv_active
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  logic [31:0] cnt_reg;
  logic        run_reg;
  int          exp_len;
  assign exp_len = o_fast_mode ? CONV_FAST_CYCLES : CONV_CYCLES;
  // counts the length of a conversion seen to start
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_reg <= 32'h0000_0000;
      run_reg <= 1'b0;
    end else if ($rose(o_conv_active)) begin
      cnt_reg <= 32'h0000_0001;
      run_reg <= 1'b1;
    end else if (o_conv_active) begin
      cnt_reg <= cnt_reg + 32'h0000_0001;
    end else begin
      cnt_reg <= 32'h0000_0000;
      run_reg <= 1'b0;
    end
  end
  property p_sda_open; o_sda_out == 1'b0; endproperty
  property p_ack_stands; $rose(o_sda_oe) |-> o_sda_oe [*6]; endproperty
  property p_standby_quiet; i_chip_sel_n [*4] |=> !o_sda_oe; endproperty
  property p_powered_off; i_chip_sel_n [*5] |=> !o_powered; endproperty
  property p_powered_on; !i_chip_sel_n [*5] |=> o_powered; endproperty
  property p_ctrl_hold;
    $changed({o_fast_mode, o_temp_sel, o_heater_on}) |-> $past(!i_chip_sel_n, 2);
  endproperty
  property p_conv_time;
    $fell(o_conv_active) && run_reg |-> int'(cnt_reg) + 8 >= exp_len && int'(cnt_reg) <= exp_len + 8;
  endproperty
  property p_conv_bound; o_conv_active && run_reg |-> int'(cnt_reg) <= exp_len + 8; endproperty
  a_sda_open: assert property (p_sda_open) else $error("sda driven high");
  a_ack_stands: assert property (p_ack_stands) else $error("sda low too short");
  a_standby_quiet: assert property (p_standby_quiet) else $error("drive in standby");
  a_powered_off: assert property (p_powered_off) else $error("power not off");
  a_powered_on: assert property (p_powered_on) else $error("power not on");
  a_ctrl_hold: assert property (p_ctrl_hold) else $error("control changed");
  a_conv_time: assert property (p_conv_time) else $error("conversion length");
  a_conv_bound: assert property (p_conv_bound) else $error("conversion too long");
  c_fast: cover property ($fell(o_conv_active) && run_reg && o_fast_mode);
  c_ack: cover property ($rose(o_sda_oe));
  c_conv: cover property ($rose(o_conv_active));
endmodule // hts_sensor_port_asserts

bind hts_sensor_port hts_sensor_port_asserts #(
  .CONV_CYCLES(CONV_CYCLES), .CONV_FAST_CYCLES(CONV_FAST_CYCLES)
) i_asserts (
  .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_scl(i_scl), .i_sda(i_sda),
  .i_chip_sel_n(i_chip_sel_n), .i_meas_result(i_meas_result), .o_sda_out(o_sda_out),
  .o_sda_oe(o_sda_oe), .o_heater_on(o_heater_on), .o_temp_sel(o_temp_sel),
  .o_fast_mode(o_fast_mode), .o_powered(o_powered), .o_conv_active(o_conv_active)
);

/* File: verification/hts_i2c_host.sv */
`timescale 1ns/1ps
// ----------------------------------------
// bus controller model
// ----------------------------------------
module hts_i2c_host (
  input  wire logic i_sys_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda
);
  // both lines idle high, scl still between frames
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask
  // one bit of 160 ns: 5 clocks low, 3 high
  task automatic bit_io(input logic b, output logic r);
    tick(1);
    o_sda <= b;
    tick(4);
    o_scl <= 1'b1;
    tick(2);
    r = i_sda;
    tick(1);
    o_scl <= 1'b0;
  endtask
  // start and repeated start
  task automatic start_c();
    tick(1);
    o_sda <= 1'b1;
    tick(3);
    o_scl <= 1'b1;
    tick(4);
    o_sda <= 1'b0;
    tick(4);
    o_scl <= 1'b0;
  endtask
  task automatic stop_c();
    tick(1);
    o_sda <= 1'b0;
    tick(3);
    o_scl <= 1'b1;
    tick(4);
    o_sda <= 1'b1;
    tick(8);
  endtask
  task automatic byte_io(input logic [7:0] tx, input logic ain,
                         output logic [7:0] rx, output logic aout);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], r);
      rx[i] = r;
    end
    bit_io(ain, aout);
  endtask
  // pointer write, with data byte and stop when asked
  task automatic wr(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d,
                    input logic with_d, input logic fin, output logic ok);
    logic [7:0] rx;
    logic       a;
    start_c();
    byte_io({dev, 1'b0}, 1'b1, rx, a);
    ok = !a;
    byte_io(ptr, 1'b1, rx, a);
    ok &= !a;
    if (with_d) begin
      byte_io(d, 1'b1, rx, a);
      ok &= !a;
    end
    if (fin) stop_c();
  endtask
  // pointer write, repeated start, one or two bytes back
  task automatic rd(input logic [6:0] dev, input logic [7:0] ptr, input logic two,
                    output logic [15:0] v, output logic ok);
    logic [7:0] rx;
    logic       a;
    wr(dev, ptr, 8'h00, 1'b0, 1'b0, ok);
    start_c();
    byte_io({dev, 1'b1}, 1'b1, rx, a);
    ok &= !a;
    byte_io(8'hff, !two, v[15:8], a);
    v[7:0] = 8'h00;
    if (two) byte_io(8'hff, 1'b1, v[7:0], a);
    stop_c();
  endtask
endmodule // hts_i2c_host

/* File: verification/hts_sensor_port_test.sv */
`timescale 1ns/1ps
// ----------------------------------------
// testbench
// ----------------------------------------
module hts_sensor_port_test
  import hts_pkg::*;
;
  localparam logic [6:0] DEV = HTS_BUS_ADDR;
  typedef struct packed {logic wr; logic [7:0] ptr, data, exp;} hts_row_t;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        cs_n = 1'b0;
  logic [15:0] meas = 16'h1234;
  logic        scl, host_sda, sda_out, sda_oe, heater, temp, fast, powered, conv, ok;
  logic [15:0] v;
  wire         sda = host_sda & (sda_oe ? sda_out : 1'b1); // pull-up when released
  int          miscompares = 0, checks = 0, cycles = 0;
  hts_row_t    rows [8] = '{
    '{1'b0, HTS_REG_STATUS, 8'h00, 8'h00},
    '{1'b0, HTS_REG_RES_HI, 8'h00, 8'h12},
    '{1'b0, HTS_REG_RES_LO, 8'h00, 8'h34},
    '{1'b0, HTS_REG_IDENTITY, 8'h00, {HTS_IDENTITY_CODE, 4'h0}},
    '{1'b0, 8'h05, 8'h00, 8'h00},
    '{1'b1, HTS_REG_CONTROL, 8'h22, 8'h22},
    '{1'b1, HTS_REG_CONTROL, 8'h10, 8'h10},
    '{1'b1, HTS_REG_RES_HI, 8'hff, 8'h12}};
  always #10 clk = ~clk;
  hts_sensor_port #(.CONV_CYCLES(2000), .CONV_FAST_CYCLES(1000)) i_dut (
    .i_sys_clk(clk), .i_reset_n(reset_n), .i_scl(scl), .i_sda(sda),
    .i_chip_sel_n(cs_n), .i_meas_result(meas), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
    .o_heater_on(heater), .o_temp_sel(temp), .o_fast_mode(fast), .o_powered(powered),
    .o_conv_active(conv));
  hts_i2c_host i_host (.i_sys_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda(host_sda));
  task automatic end_sim();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // waits a bounded time for the busy flag to drop
  task automatic wait_conv();
    int n;
    n = 0;
    while (conv !== 1'b0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    cmp_bit(conv, 1'b0);
  endtask
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      end_sim();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    repeat (8) @(posedge clk);
    cmp_bit(powered, 1'b1);
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        i_host.wr(DEV, rows[i].ptr, rows[i].data, 1'b1, 1'b1, ok);
        cmp_bit(ok, 1'b1);
      end
      i_host.rd(DEV, rows[i].ptr, 1'b0, v, ok);
      cmp_bit(ok, 1'b1);
      cmp_byte(v[15:8], rows[i].exp);
    end
    cmp_bit(temp, 1'b1);
    // foreign address is ignored
    i_host.wr(DEV ^ 7'h01, HTS_REG_CONTROL, 8'h01, 1'b1, 1'b1, ok);
    cmp_bit(ok, 1'b0);
    cmp_bit(conv, 1'b0);
    // temperature conversion, busy poll, two-byte result
    meas <= 16'h0b40;
    i_host.wr(DEV, HTS_REG_CONTROL, 8'h11, 1'b1, 1'b1, ok);
    cmp_bit(conv, 1'b1);
    i_host.rd(DEV, HTS_REG_STATUS, 1'b0, v, ok);
    cmp_byte(v[15:8], 8'h01);
    wait_conv();
    i_host.rd(DEV, HTS_REG_RES_HI, 1'b1, v, ok);
    cmp_byte(v[15:8], 8'h0b);
    cmp_byte(v[7:0], 8'h40);
    // fast humidity conversion
    meas <= 16'h4a00;
    i_host.wr(DEV, HTS_REG_CONTROL, 8'h21, 1'b1, 1'b1, ok);
    cmp_bit(fast, 1'b1);
    cmp_bit(temp, 1'b0);
    wait_conv();
    i_host.rd(DEV, HTS_REG_RES_HI, 1'b1, v, ok);
    cmp_byte(v[15:8], 8'h4a);
    cmp_byte(v[7:0], 8'h00);
    // deselected device stays silent
    cs_n <= 1'b1;
    i_host.wr(DEV, HTS_REG_CONTROL, 8'h01, 1'b1, 1'b1, ok);
    cmp_bit(ok, 1'b0);
    cmp_bit(powered, 1'b0);
    cs_n <= 1'b0;
    repeat (8) @(posedge clk);
    // reset in mid-conversion
    i_host.wr(DEV, HTS_REG_CONTROL, 8'h13, 1'b1, 1'b1, ok);
    cmp_bit(heater, 1'b1);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    repeat (8) @(posedge clk);
    cmp_bit(heater, 1'b0);
    wait_conv();
    i_host.rd(DEV, HTS_REG_CONTROL, 1'b0, v, ok);
    cmp_byte(v[15:8], HTS_CTRL_RESET);
    end_sim();
  end
endmodule // hts_sensor_port_test
